// *** tick_timer.sv ***
// core tick timer: prescaler, 8-bit counter, periodic divider, watchdog base
// assumes an apb master on CLK and a synchronous active-high SRST
`timescale 1ns/1ps
`include "tick_timer_defs.svh"
module tick_timer (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // events
    output logic IRQ,
    output logic WATCHDOG_RESET
);
    import tick_timer_pkg::*;

    tick_state_t s;
    tick_state_t next_s;
    logic access;
    logic wr;
    logic [7:0] idx;
    logic [7:0] ctl_rd;
    logic tap_now;
    logic ovf_event;
    logic per_event;
    logic wdog_clear;
    logic mapped;

    assign access = PSEL && PENABLE && !s.pready;
    assign wr = access && PWRITE && mapped;
    assign idx = PADDR[9:2];
    assign mapped = PADDR[1:0] == 2'h0 && PADDR[31:10] == 22'h0 &&
        (idx == `TICK_IDX_STATUS_CONTROL || idx == `TICK_IDX_COUNT_VALUE ||
         idx == `TICK_IDX_WATCHDOG_SERVICE);

    // chain is one binary counter; bit k toggles every 2^k bus clocks,
    // so a synchronous counter behaves like the ripple chain without skew
    assign ovf_event = &s.chain[9:0];
    // periodic base E/2048 is chain bit 10; taps are bits 10..13 falling
    always_comb begin
        unique case (s.rate)
            2'h0: tap_now = s.chain[`TICK_PER_BASE_BIT];
            2'h1: tap_now = s.chain[`TICK_PER_BASE_BIT + 1];
            2'h2: tap_now = s.chain[`TICK_PER_BASE_BIT + 2];
            default: tap_now = s.chain[`TICK_PER_BASE_BIT + 3];
        endcase
    end
    // tap falling edge = one period of 2^(11+n) elapsed; a tap switch mid
    // count can lose or add one event, software must service first
    assign per_event = s.per_tap && !tap_now;
    assign wdog_clear = wr && idx == `TICK_IDX_WATCHDOG_SERVICE &&
        !PWDATA[0];

    always_comb begin
        ctl_rd = 8'h00;
        ctl_rd[`TICK_BIT_OVF_FLAG] = s.ovf_flag;
        ctl_rd[`TICK_BIT_PER_FLAG] = s.per_flag;
        ctl_rd[`TICK_BIT_OVF_IE] = s.ovf_ie;
        ctl_rd[`TICK_BIT_PER_IE] = s.per_ie;
        ctl_rd[1:0] = s.rate; // clear bits stay zero
    end

    always_comb begin
        next_s = s;
        next_s.chain = s.chain + 19'h1;
        next_s.per_tap = tap_now;
        next_s.pready = access;
        next_s.slverr = access && !mapped;
        next_s.wdog_reset = 1'b0;
        if (wdog_clear) begin
            next_s.wdog = 3'h0;
        end else if (per_event) begin
            next_s.wdog = s.wdog + 3'h1;
            if (s.wdog == `TICK_WDOG_LAST) begin
                next_s.wdog_reset = 1'b1;
            end
        end
        if (wr && idx == `TICK_IDX_STATUS_CONTROL) begin
            next_s.ovf_ie = PWDATA[`TICK_BIT_OVF_IE];
            next_s.per_ie = PWDATA[`TICK_BIT_PER_IE];
            next_s.rate = PWDATA[1:0];
            if (PWDATA[`TICK_BIT_OVF_CLR]) begin
                next_s.ovf_flag = 1'b0;
            end
            if (PWDATA[`TICK_BIT_PER_CLR]) begin
                next_s.per_flag = 1'b0;
            end
        end
        // set beats a clear in the same cycle
        if (ovf_event) begin
            next_s.ovf_flag = 1'b1;
        end
        if (per_event) begin
            next_s.per_flag = 1'b1;
        end
        next_s.irq = (next_s.ovf_flag && next_s.ovf_ie) ||
            (next_s.per_flag && next_s.per_ie);
        next_s.prdata = 32'h0;
        if (access && !PWRITE && mapped) begin
            if (idx == `TICK_IDX_STATUS_CONTROL) begin
                next_s.prdata = {24'h0, ctl_rd};
            end else if (idx == `TICK_IDX_COUNT_VALUE) begin
                next_s.prdata = {24'h0, s.chain[9:2]};
            end
        end
        if (SRST) begin
            next_s = '0;
            next_s.rate = `TICK_RATE_RESET;
        end
    end

    always_ff @(posedge CLK) begin
        s <= next_s;
    end

    // unmapped addresses answer with an error, read zero, write nothing
    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.slverr;
    assign IRQ = s.irq;
    assign WATCHDOG_RESET = s.wdog_reset;

    property p_ovf_period;
        @(posedge CLK) disable iff (SRST)
        ovf_event |=> !ovf_event [*8];
    endproperty
    a_ovf_period: assert property (p_ovf_period)
        else $error("overflow event repeated too soon");

    property p_ovf_flag;
        @(posedge CLK) disable iff (SRST)
        ovf_event |=> s.ovf_flag;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("overflow flag not set after wrap");

    property p_per_flag;
        @(posedge CLK) disable iff (SRST)
        per_event |=> s.per_flag;
    endproperty
    a_per_flag: assert property (p_per_flag)
        else $error("periodic flag not set after tap event");

    property p_irq;
        @(posedge CLK) disable iff (SRST)
        IRQ == ((s.ovf_flag && s.ovf_ie) || (s.per_flag && s.per_ie));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not match flags and enables");

    property p_per_irq;
        @(posedge CLK) disable iff (SRST)
        (s.per_flag && s.per_ie) |-> IRQ;
    endproperty
    a_per_irq: assert property (p_per_irq)
        else $error("periodic interrupt missing");

    property p_ovf_clear;
        @(posedge CLK) disable iff (SRST)
        (wr && idx == `TICK_IDX_STATUS_CONTROL && PWDATA[3] && !ovf_event)
        |=> !s.ovf_flag;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("overflow flag not cleared by write one");

    property p_per_clear;
        @(posedge CLK) disable iff (SRST)
        (wr && idx == `TICK_IDX_STATUS_CONTROL && PWDATA[2] && !per_event)
        |=> !s.per_flag;
    endproperty
    a_per_clear: assert property (p_per_clear)
        else $error("periodic flag not cleared by write one");

    property p_clear_bits_zero;
        @(posedge CLK) disable iff (SRST)
        PREADY && !PWRITE && idx == `TICK_IDX_STATUS_CONTROL |->
            PRDATA[3:2] == 2'h0;
    endproperty
    a_clear_bits_zero: assert property (p_clear_bits_zero)
        else $error("clear bits read nonzero");

    property p_reset_rate;
        @(posedge CLK)
        SRST |=> s.rate == 2'h3 && s.chain == 19'h0 && !s.ovf_ie;
    endproperty
    a_reset_rate: assert property (p_reset_rate)
        else $error("reset state wrong");

    property p_wdog_service;
        @(posedge CLK) disable iff (SRST)
        wdog_clear |=> s.wdog == 3'h0 ##1 !WATCHDOG_RESET;
    endproperty
    a_wdog_service: assert property (p_wdog_service)
        else $error("watchdog stage not cleared by service");

    // a periodic event lands only where every bit below its tap is zero
    property p_rate0_period;
        @(posedge CLK) disable iff (SRST)
        per_event && s.rate == 2'h0 && s.rate == $past(s.rate) |->
            s.chain[10:0] == 11'h0;
    endproperty
    a_rate0_period: assert property (p_rate0_period)
        else $error("periodic event off its 2^11 grid");

    property p_rate1_period;
        @(posedge CLK) disable iff (SRST)
        per_event && s.rate == 2'h1 && s.rate == $past(s.rate) |->
            s.chain[11:0] == 12'h0;
    endproperty
    a_rate1_period: assert property (p_rate1_period)
        else $error("periodic event off its 2^12 grid");

    property p_rate2_period;
        @(posedge CLK) disable iff (SRST)
        per_event && s.rate == 2'h2 && s.rate == $past(s.rate) |->
            s.chain[12:0] == 13'h0;
    endproperty
    a_rate2_period: assert property (p_rate2_period)
        else $error("periodic event off its 2^13 grid");

    property p_rate3_period;
        @(posedge CLK) disable iff (SRST)
        per_event && s.rate == 2'h3 && s.rate == $past(s.rate) |->
            s.chain[13:0] == 14'h0;
    endproperty
    a_rate3_period: assert property (p_rate3_period)
        else $error("periodic event off its 2^14 grid");

    property p_ovf_wrap;
        @(posedge CLK) disable iff (SRST)
        ovf_event |=> s.chain[9:0] == 10'h0;
    endproperty
    a_ovf_wrap: assert property (p_ovf_wrap)
        else $error("counter did not wrap after overflow");

    property p_count_read;
        @(posedge CLK) disable iff (SRST)
        access && !PWRITE && mapped && idx == `TICK_IDX_COUNT_VALUE |=>
            PRDATA[7:0] == $past(s.chain[9:2]);
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("count read does not show the counter");

    property p_count_upper;
        @(posedge CLK) disable iff (SRST)
        access && !PWRITE && mapped |=> PRDATA[31:8] == 24'h0;
    endproperty
    a_count_upper: assert property (p_count_upper)
        else $error("upper read data not zero");

    property p_ovf_hold;
        @(posedge CLK) disable iff (SRST)
        !ovf_event && !(wr && idx == `TICK_IDX_STATUS_CONTROL && PWDATA[3])
        |=> $stable(s.ovf_flag);
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow flag changed without cause");

    property p_per_hold;
        @(posedge CLK) disable iff (SRST)
        !per_event && !(wr && idx == `TICK_IDX_STATUS_CONTROL && PWDATA[2])
        |=> $stable(s.per_flag);
    endproperty
    a_per_hold: assert property (p_per_hold)
        else $error("periodic flag changed without cause");

    property p_wdog_step;
        @(posedge CLK) disable iff (SRST)
        per_event && !wdog_clear |=> s.wdog == 3'($past(s.wdog) + 3'h1);
    endproperty
    a_wdog_step: assert property (p_wdog_step)
        else $error("watchdog stage did not count the event");

    property p_wdog_hold;
        @(posedge CLK) disable iff (SRST)
        !per_event && !wdog_clear |=> $stable(s.wdog);
    endproperty
    a_wdog_hold: assert property (p_wdog_hold)
        else $error("watchdog stage moved without cause");

    property p_wdog_timeout;
        @(posedge CLK) disable iff (SRST)
        per_event && !wdog_clear && s.wdog == 3'h7 |=> WATCHDOG_RESET;
    endproperty
    a_wdog_timeout: assert property (p_wdog_timeout)
        else $error("watchdog timeout not signalled");

    property p_wdog_pulse;
        @(posedge CLK) disable iff (SRST)
        WATCHDOG_RESET |=> !WATCHDOG_RESET;
    endproperty
    a_wdog_pulse: assert property (p_wdog_pulse)
        else $error("watchdog reset longer than one cycle");

    property p_pready_pulse;
        @(posedge CLK) disable iff (SRST)
        PREADY |=> !PREADY;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse)
        else $error("ready longer than one cycle");

    property p_ie_reset;
        @(posedge CLK)
        SRST |=> !s.ovf_ie && !s.per_ie;
    endproperty
    a_ie_reset: assert property (p_ie_reset)
        else $error("enables not cleared by reset");

    property p_flag_reset;
        @(posedge CLK)
        SRST |=> !s.ovf_flag && !s.per_flag;
    endproperty
    a_flag_reset: assert property (p_flag_reset)
        else $error("flags not cleared by reset");

    property p_chain_reset;
        @(posedge CLK)
        SRST |=> s.chain == 19'h0 && s.wdog == 3'h0;
    endproperty
    a_chain_reset: assert property (p_chain_reset)
        else $error("chain not cleared by reset");

    property p_irq_ovf;
        @(posedge CLK) disable iff (SRST)
        (s.ovf_flag && s.ovf_ie) |-> IRQ;
    endproperty
    a_irq_ovf: assert property (p_irq_ovf)
        else $error("overflow interrupt missing");

    property p_slverr;
        @(posedge CLK) disable iff (SRST)
        access && !mapped |=> PSLVERR && PRDATA == 32'h0;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped access not refused");

    property p_rate_write;
        @(posedge CLK) disable iff (SRST)
        wr && idx == `TICK_IDX_STATUS_CONTROL |=>
            s.rate == $past(PWDATA[1:0]);
    endproperty
    a_rate_write: assert property (p_rate_write)
        else $error("rate select not written");

    property p_no_write_unmapped;
        @(posedge CLK) disable iff (SRST)
        access && PWRITE && !mapped |=>
            $stable(s.rate) && $stable(s.ovf_ie) && $stable(s.per_ie);
    endproperty
    a_no_write_unmapped: assert property (p_no_write_unmapped)
        else $error("unmapped write changed the control register");
endmodule // tick_timer

// *** tick_timer_defs.svh ***
// offsets, field positions, reset values and timing counts of the tick timer
// assumes an apb slave with 32-bit data; offsets 0x08/0x09 are word indices
`ifndef TICK_TIMER_DEFS_SVH
`define TICK_TIMER_DEFS_SVH
`define TICK_IDX_STATUS_CONTROL 8'h08
`define TICK_IDX_COUNT_VALUE 8'h09
`define TICK_IDX_WATCHDOG_SERVICE 8'h0a
`define TICK_BIT_OVF_FLAG 7
`define TICK_BIT_PER_FLAG 6
`define TICK_BIT_OVF_IE 5
`define TICK_BIT_PER_IE 4
`define TICK_BIT_OVF_CLR 3
`define TICK_BIT_PER_CLR 2
`define TICK_RATE_RESET 2'h3
`define TICK_CHAIN_BITS 19
`define TICK_PRESCALE_BITS 2
`define TICK_PER_BASE_BIT 10
`define TICK_WDOG_LAST 3'h7
`endif

// *** tick_timer_pkg.sv ***
// types of the tick timer
// widths are written out here as literals; the defs header is not included
package tick_timer_pkg;
    typedef logic [1:0] rate_t;
    typedef struct packed {
        logic [18:0] chain;
        logic [2:0] wdog;
        logic wdog_reset;
        logic ovf_flag;
        logic per_flag;
        logic ovf_ie;
        logic per_ie;
        rate_t rate;
        logic per_tap;
        logic irq;
        logic pready;
        logic slverr;
        logic [31:0] prdata;
    } tick_state_t;
endpackage

// *** core_tick_timer_periodic_irq_test.sv ***
// self-checking bench for the tick timer over apb
// assumes the design answers each apb access and pulses WATCHDOG_RESET
`timescale 1ns/1ps
`define CHK(g, w) begin n_tests++; if ((g) !== (w)) begin bad_count++; \
    $display("mismatch at %0t: got %h want %h", $time, g, w); end end
module core_tick_timer_periodic_irq_test;
    logic CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, r;
    logic PREADY, PSLVERR, IRQ, WATCHDOG_RESET, err;
    int bad_count = 0, n_tests = 0;
    tick_timer tick_timer_i (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
        .WATCHDOG_RESET(WATCHDOG_RESET));
    always #10 CLK = ~CLK;
    task automatic xfer(input logic w, input logic [31:0] a, d);
        @(posedge CLK);
        PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1;
        do begin @(posedge CLK); end while (PREADY !== 1'b1);
        r = PRDATA;
        err = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task automatic reset_values();
        xfer(0, 32'h24, 0);
        `CHK(r, 32'h0)
        xfer(0, 32'h20, 0);
        `CHK(r, 32'h3)
        xfer(0, 32'h30, 0);
        `CHK({err, r}, {1'b1, 32'h0})
    endtask
    task automatic count_runs();
        logic [7:0] a;
        xfer(0, 32'h24, 0);
        a = r[7:0];
        idle(37);
        xfer(0, 32'h24, 0);
        // 41 clocks between samples, one tick per four clocks
        `CHK((r[7:0] - a) inside {8'ha, 8'hb}, 1'b1)
    endtask
    task automatic overflow();
        xfer(1, 32'h20, 32'h2b);
        xfer(0, 32'h20, 0);
        `CHK(r, 32'h23)
        idle(1030);
        xfer(0, 32'h20, 0);
        `CHK(r, 32'ha3)
        `CHK(IRQ, 1'b1)
        // the flag bit cannot be written, only cleared
        xfer(1, 32'h20, 32'h03);
        xfer(0, 32'h20, 0);
        `CHK(r, 32'h83)
        `CHK(IRQ, 1'b0)
        xfer(1, 32'h20, 32'h0b);
        xfer(0, 32'h20, 0);
        `CHK(r, 32'h03)
    endtask
    task automatic periodic();
        xfer(1, 32'h28, 32'h0);
        xfer(1, 32'h20, 32'h14);
        xfer(0, 32'h20, 0);
        `CHK(r & 32'h5f, 32'h10)
        idle(2060);
        xfer(0, 32'h20, 0);
        `CHK(r & 32'h5f, 32'h50)
        `CHK(IRQ, 1'b1)
        xfer(1, 32'h20, 32'h04);
        xfer(0, 32'h20, 0);
        `CHK(r & 32'h5f, 32'h0)
        `CHK(IRQ, 1'b0)
    endtask
    task automatic watchdog();
        int k;
        k = 0;
        xfer(1, 32'h28, 32'h0);
        while (WATCHDOG_RESET !== 1'b1 && k < 17000) begin
            @(posedge CLK);
            k++;
        end
        // service may land anywhere within one periodic interval
        `CHK(k inside {[14330 : 16400]}, 1'b1)
        @(posedge CLK);
        `CHK(WATCHDOG_RESET, 1'b0)
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        SRST <= 0;
        reset_values();
        count_runs();
        overflow();
        periodic();
        watchdog();
        end_sim();
    end
    initial begin
        // the run needs about 18500 clocks
        #1000000;
        bad_count++;
        end_sim();
    end
endmodule // core_tick_timer_periodic_irq_test
